/* File: design/uoec_top.sv */
// How it works
// - nyet suppressed: ack every good packet
// - iso: bit 12 flags pid error
// - mode 0 dma plus irq; mode 1 split
// - bits 10 and 9 read zero
// - bit 8 partial iso packet, clears with ready
// - writing bit 7 zeroes data toggle
// - bit 6 set when stall sent
// - bit 5 stalls data packets, not iso
// - bit 4 drops packet, resets pointers, ready
// - iso crc error flag with ready
// - iso overrun when packet hits full buffer
// - bit 1 shows buffer cannot take packet
// - bit 0 packet ready, irq, software clears
// - 13-bit live byte count of buffer
// - sixteen fifo addresses, read unloads out
// - 16-bit bus window 20h to 3Fh; this block has only the 32-bit Wishbone bus
// - 32-bit bus window 20h to 5Fh
// - fifo accesses 8 to 32 bits
// - endpoint totals read-only info byte
// - dma channels and ram width info
//
// Implementation choice: register access over Wishbone.
`include "uoec_regs.svh"

module uoec_top #(
  parameter int EP_NUM = 1,            // endpoint served by this block
  parameter int RX_DEPTH = 64,         // packet buffer bytes
  parameter int MAX_PAYLOAD = 64,      // max packet size in bytes
  parameter logic [3:0] RX_EP_TOTAL = 4'h1,
  parameter logic [3:0] TX_EP_TOTAL = 4'h1,
  parameter logic [3:0] DMA_CH_TOTAL = 4'h1,
  parameter logic [3:0] RAM_AW_LESS_ONE = 4'h5
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [31:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // receive link from the transceiver side
  input wire logic high_speed_i,
  input wire logic high_bw_i,
  input wire logic pkt_start_i,
  input wire logic pkt_byte_valid_i,
  input wire logic [7:0] pkt_byte_i,
  input wire logic pkt_end_i,
  input wire logic pkt_crc_err_i,
  input wire logic pkt_pid_err_i,
  input wire logic pkt_partial_i,
  input wire logic pkt_toggle_i,
  // answers to the link and system
  output logic hs_valid_o,
  output uoec_pkg::uoec_hs_t hs_code_o,
  output logic data_toggle_o,
  output logic dma_req_o,
  output logic ep_irq_o
);
  import uoec_pkg::*;

  localparam int AW = $clog2(RX_DEPTH);
  localparam int PW = AW + 1;
  localparam logic [PW-1:0] DEPTH_P = PW'(RX_DEPTH);
  localparam logic [PW-1:0] MAXP_P = PW'(MAX_PAYLOAD);

  // ========================================================
  // state declarations
  // ========================================================
  logic [7:0] buf_reg [RX_DEPTH];     // packet storage
  logic [PW-1:0] wr_ptr_reg;          // bytes loaded
  logic [PW-1:0] rd_ptr_reg;          // bytes unloaded
  uoec_rx_state_t rx_state_reg;       // receive sequencer
  uoec_hs_t drop_code_reg;            // answer for a dropped packet
  logic drop_answer_reg;              // dropped packet needs answer
  logic iso_reg;                      // isochronous mode
  logic dma_en_reg;                   // dma requests enabled
  logic dma_mode_reg;                 // request mode 1 when high
  logic nyet_sup_reg;                 // nyet suppression
  logic stall_req_reg;                // stall requested
  logic toggle_reg;                   // expected data toggle
  logic ack_reg;
  logic [31:0] dat_reg;
  logic hs_valid_reg;
  uoec_hs_t hs_code_reg;
  logic dma_req_reg;
  logic irq_reg;

  // flag vector from the sticky flag bank
  // order: ready, stall sent, overrun, crc, partial, pid error
  logic [5:0] flag_set;
  logic [5:0] flag_clr;
  logic [5:0] flag_q;
  logic pkt_rdy;
  logic stall_sent;
  logic overrun;
  logic crc_flag;
  logic partial_flag;
  logic pid_flag;
  assign pkt_rdy = flag_q[0];
  assign stall_sent = flag_q[1];
  assign overrun = flag_q[2];
  assign crc_flag = flag_q[3];
  assign partial_flag = flag_q[4];
  assign pid_flag = flag_q[5];

  // ========================================================
  // bus decode
  // ========================================================
  logic req;              // new request, acted on when ack rises
  logic wr_csr;
  logic hit_csr;
  logic hit_fifo;
  logic own_fifo;
  logic [4:0] fifo_word;
  logic [PW-1:0] avail;   // unread bytes in the buffer
  logic [2:0] nsel;       // lanes asked for
  logic [PW-1:0] take;    // bytes really unloaded
  logic [31:0] fifo_rd;
  logic [31:0] reg_rd;
  logic [15:0] csr_rd;
  logic [12:0] count;
  logic full;

  always_comb begin
    req = wb_cyc_i & wb_stb_i & ~ack_reg;
    hit_csr = wb_adr_i == `UOEC_CSR_ADDR;
    wr_csr = req & wb_we_i & hit_csr;
    // one word per endpoint, endpoint 15 at 5Ch
    hit_fifo = (wb_adr_i >= `UOEC_FIFO_FIRST) &&
               (wb_adr_i <= `UOEC_FIFO_LAST) && (wb_adr_i[1:0] == 2'h0);
    fifo_word = wb_adr_i[6:2] - `UOEC_FIFO_EP0_WORD;
    own_fifo = hit_fifo && (fifo_word == 5'(EP_NUM));
  end

  // live count follows every load and unload
  assign avail = wr_ptr_reg - rd_ptr_reg;
  assign count = 13'(avail);
  // single packet buffer: a held packet blocks the next one
  assign full = pkt_rdy;

  // ========================================================
  // fifo read lanes
  // ========================================================
  // bytes fill the selected lanes from the lowest up, so any
  // contiguous 8/16/24/32-bit access unloads in stream order
  always_comb begin
    logic [PW-1:0] n;
    logic [PW-1:0] idx;
    n = '0;
    idx = '0;
    fifo_rd = 32'h0000_0000;
    for (int l = 0; l < 4; l++) begin
      if (wb_sel_i[l]) begin
        idx = rd_ptr_reg + n;
        if (n < avail) begin
          fifo_rd[8*l +: 8] = buf_reg[idx[AW-1:0]];
        end
        n = n + 1'b1;
      end
    end
    nsel = 3'(n);
    // never run past the loaded bytes
    take = (PW'(nsel) > avail) ? avail : PW'(nsel);
  end

  // ========================================================
  // register read mux
  // ========================================================
  always_comb begin
    csr_rd = `UOEC_CSR_RESET;
    csr_rd[`UOEC_B_PKT_RDY] = pkt_rdy;
    csr_rd[`UOEC_B_FULL] = full;
    csr_rd[`UOEC_B_OVERRUN] = iso_reg & overrun;
    csr_rd[`UOEC_B_CRC] = iso_reg & crc_flag;
    csr_rd[`UOEC_B_STALL_REQ] = stall_req_reg;
    csr_rd[`UOEC_B_STALL_SENT] = stall_sent;
    csr_rd[`UOEC_B_PARTIAL] = iso_reg & partial_flag;
    csr_rd[`UOEC_B_DMA_MODE] = dma_mode_reg;
    // same bit, two meanings by transfer type
    csr_rd[`UOEC_B_NYET] = iso_reg ? pid_flag : nyet_sup_reg;
    csr_rd[`UOEC_B_DMA_EN] = dma_en_reg;
    csr_rd[`UOEC_B_ISO] = iso_reg;
    if (hit_csr) begin
      reg_rd = {16'h0000, csr_rd};
    end else if (wb_adr_i == `UOEC_COUNT_ADDR) begin
      reg_rd = {19'h0_0000, count};
    end else if (wb_adr_i == `UOEC_EP_TOTAL_ADDR) begin
      reg_rd = {24'h00_0000, RX_EP_TOTAL, TX_EP_TOTAL};
    end else if (wb_adr_i == `UOEC_MEM_INFO_ADDR) begin
      reg_rd = {24'h00_0000, DMA_CH_TOTAL, RAM_AW_LESS_ONE};
    end else if (own_fifo) begin
      reg_rd = fifo_rd;
    end else begin
      // other endpoints and unmapped words read as zero
      reg_rd = 32'h0000_0000;
    end
  end

  // ========================================================
  // wishbone answer: ack one edge after the request
  // ========================================================
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg <= 1'b0;
      dat_reg <= 32'h0000_0000;
    end else if (ce_i) begin
      ack_reg <= req;
      if (req && !wb_we_i) begin
        dat_reg <= reg_rd;
      end
    end
  end

  // ========================================================
  // software control bits
  // ========================================================
  logic wr_lo;
  logic wr_hi;
  assign wr_lo = wr_csr & wb_sel_i[0];
  assign wr_hi = wr_csr & wb_sel_i[1];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      iso_reg <= 1'b0;
      dma_en_reg <= 1'b0;
      dma_mode_reg <= 1'b0;
      nyet_sup_reg <= 1'b0;
      stall_req_reg <= 1'b0;
    end else if (ce_i) begin
      if (wr_hi) begin
        iso_reg <= wb_dat_i[`UOEC_B_ISO];
        dma_en_reg <= wb_dat_i[`UOEC_B_DMA_EN];
        dma_mode_reg <= wb_dat_i[`UOEC_B_DMA_MODE];
        // in iso mode bit 12 is the pid flag, not this control
        if (!iso_reg) begin
          nyet_sup_reg <= wb_dat_i[`UOEC_B_NYET];
        end
      end
      if (wr_lo) begin
        stall_req_reg <= wb_dat_i[`UOEC_B_STALL_REQ];
      end
    end
  end

  // ========================================================
  // receive decisions
  // ========================================================
  logic flush;       // software drop of the held packet
  logic rdy_clr;     // software clear of packet ready
  logic pkt_done;    // end of a packet being loaded
  logic accept;      // packet becomes ready for software
  logic discard;     // loaded bytes thrown away
  logic is_max;
  logic good_bulk;

  always_comb begin
    flush = wr_lo & wb_dat_i[`UOEC_B_FLUSH];
    rdy_clr = flush | (wr_lo & ~wb_dat_i[`UOEC_B_PKT_RDY]);
    pkt_done = (rx_state_reg == RX_LOAD) & pkt_end_i;
    good_bulk = ~pkt_crc_err_i & (pkt_toggle_i == toggle_reg);
    // iso keeps damaged packets and flags them
    accept = pkt_done & (iso_reg | good_bulk);
    discard = pkt_done & ~accept;
    is_max = wr_ptr_reg == MAXP_P;
  end

  // sticky flag bank
  always_comb begin
    flag_set[0] = accept;
    flag_set[1] = (rx_state_reg == RX_DROP) & pkt_end_i &
                  (drop_code_reg == `UOEC_HS_STALL);
    flag_set[2] = pkt_start_i & (rx_state_reg == RX_IDLE) &
                  ~(stall_req_reg & ~iso_reg) & full & iso_reg;
    flag_set[3] = accept & iso_reg & pkt_crc_err_i;
    flag_set[4] = accept & iso_reg & high_bw_i & pkt_partial_i;
    flag_set[5] = accept & iso_reg & pkt_pid_err_i;
    flag_clr[0] = rdy_clr;
    flag_clr[1] = wr_lo & ~wb_dat_i[`UOEC_B_STALL_SENT];
    flag_clr[2] = wr_lo & ~wb_dat_i[`UOEC_B_OVERRUN];
    // crc and partial flags follow packet ready down
    flag_clr[3] = rdy_clr;
    flag_clr[4] = rdy_clr;
    flag_clr[5] = wr_hi & iso_reg & ~wb_dat_i[`UOEC_B_NYET];
  end

  uoec_flag #(
    .W(6)
  ) u_flags (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .set_i(flag_set),
    .clr_i(flag_clr),
    .flag_o(flag_q)
  );

  // ========================================================
  // receive sequencer and handshake
  // ========================================================
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_state_reg <= RX_IDLE;
      drop_code_reg <= `UOEC_HS_ACK;
      drop_answer_reg <= 1'b0;
      hs_valid_reg <= 1'b0;
      hs_code_reg <= `UOEC_HS_ACK;
    end else if (ce_i) begin
      hs_valid_reg <= 1'b0;
      case (rx_state_reg)
        RX_IDLE: begin
          if (pkt_start_i) begin
            if (stall_req_reg && !iso_reg) begin
              rx_state_reg <= RX_DROP;
              drop_code_reg <= `UOEC_HS_STALL;
              drop_answer_reg <= 1'b1;
            end else if (full) begin
              // iso has no handshake, bulk is told to retry
              rx_state_reg <= RX_DROP;
              drop_code_reg <= `UOEC_HS_NAK;
              drop_answer_reg <= ~iso_reg;
            end else begin
              rx_state_reg <= RX_LOAD;
            end
          end
        end
        RX_LOAD: begin
          if (pkt_end_i) begin
            rx_state_reg <= RX_IDLE;
            // corrupt bulk packets get no answer at all
            if (!iso_reg && !pkt_crc_err_i) begin
              hs_valid_reg <= 1'b1;
              // single buffer is full after every good packet
              if (accept && high_speed_i && !nyet_sup_reg) begin
                hs_code_reg <= `UOEC_HS_NYET;
              end else begin
                hs_code_reg <= `UOEC_HS_ACK;
              end
            end
          end
        end
        RX_DROP: begin
          if (pkt_end_i) begin
            rx_state_reg <= RX_IDLE;
            hs_valid_reg <= drop_answer_reg;
            hs_code_reg <= drop_code_reg;
          end
        end
        default: begin
          rx_state_reg <= RX_IDLE;
        end
      endcase
    end
  end

  // ========================================================
  // buffer pointers and storage
  // ========================================================
  // flushing outside packet ready can tear a packet in flight;
  // software is expected to avoid it
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
    end else if (ce_i) begin
      // a packet landing on a clear keeps its bytes: set wins
      if ((rdy_clr && !accept) || discard) begin
        wr_ptr_reg <= '0;
        rd_ptr_reg <= '0;
      end else begin
        if ((rx_state_reg == RX_LOAD) && pkt_byte_valid_i &&
            (wr_ptr_reg < DEPTH_P)) begin
          wr_ptr_reg <= wr_ptr_reg + 1'b1;
        end
        if (req && !wb_we_i && own_fifo) begin
          rd_ptr_reg <= rd_ptr_reg + take;
        end
      end
    end
  end

  // storage has no reset: contents are don't care until loaded
  always_ff @(posedge clk_i) begin
    if (ce_i && (rx_state_reg == RX_LOAD) && pkt_byte_valid_i &&
        (wr_ptr_reg < DEPTH_P)) begin
      buf_reg[wr_ptr_reg[AW-1:0]] <= pkt_byte_i;
    end
  end

  // ========================================================
  // data toggle
  // ========================================================
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      toggle_reg <= 1'b0;
    end else if (ce_i) begin
      if (wr_lo && wb_dat_i[`UOEC_B_TOG_RST]) begin
        toggle_reg <= 1'b0;
      end else if (accept && !iso_reg) begin
        toggle_reg <= ~toggle_reg;
      end
    end
  end

  // ========================================================
  // dma request and endpoint interrupt event
  // ========================================================
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dma_req_reg <= 1'b0;
      irq_reg <= 1'b0;
    end else if (ce_i) begin
      irq_reg <= 1'b0;
      if (accept) begin
        // mode 1 routes full-size packets to dma only
        dma_req_reg <= dma_en_reg & (~dma_mode_reg | is_max);
        irq_reg <= ~(dma_en_reg & dma_mode_reg & is_max);
      end else if (!pkt_rdy || (avail == '0)) begin
        dma_req_reg <= 1'b0;
      end
    end
  end

  // ========================================================
  // outputs straight from flops
  // ========================================================
  assign wb_ack_o = ack_reg;
  assign wb_dat_o = dat_reg;
  assign hs_valid_o = hs_valid_reg;
  assign hs_code_o = hs_code_reg;
  assign data_toggle_o = toggle_reg;
  assign dma_req_o = dma_req_reg;
  assign ep_irq_o = irq_reg;

endmodule : uoec_top

/* File: design/uoec_regs.svh */
`ifndef UOEC_REGS_SVH
`define UOEC_REGS_SVH
// ==========================================================
// register byte addresses on the wishbone slave
// ==========================================================
`define UOEC_CSR_ADDR 32'h0000_0010
`define UOEC_EP_TOTAL_ADDR 32'h0000_0014
// offsets that are not word aligned are register indices
`define UOEC_COUNT_IDX 32'h1304_0018
`define UOEC_MEM_INFO_IDX 32'h1304_0079
`define UOEC_COUNT_ADDR (`UOEC_COUNT_IDX << 2)
`define UOEC_MEM_INFO_ADDR (`UOEC_MEM_INFO_IDX << 2)
// fifo window, one word per endpoint
`define UOEC_FIFO_FIRST 32'h0000_0020
`define UOEC_FIFO_LAST 32'h0000_005C
`define UOEC_FIFO_EP0_WORD 5'h08
// ==========================================================
// control/status bit positions
// ==========================================================
`define UOEC_B_PKT_RDY 0
`define UOEC_B_FULL 1
`define UOEC_B_OVERRUN 2
`define UOEC_B_CRC 3
`define UOEC_B_FLUSH 4
`define UOEC_B_STALL_REQ 5
`define UOEC_B_STALL_SENT 6
`define UOEC_B_TOG_RST 7
`define UOEC_B_PARTIAL 8
`define UOEC_B_DMA_MODE 11
`define UOEC_B_NYET 12
`define UOEC_B_DMA_EN 13
`define UOEC_B_ISO 14
`define UOEC_CSR_RESET 16'h0000
// ==========================================================
// handshake codes toward the link
// ==========================================================
`define UOEC_HS_ACK 2'h0
`define UOEC_HS_NAK 2'h1
`define UOEC_HS_STALL 2'h2
`define UOEC_HS_NYET 2'h3
`endif

/* File: design/uoec_pkg.sv */
// ==========================================================
// shared types
// ==========================================================
package uoec_pkg;
  // receive sequencer states
  typedef enum logic [1:0] {RX_IDLE, RX_LOAD, RX_DROP} uoec_rx_state_t;
  // handshake code carried to the link
  typedef logic [1:0] uoec_hs_t;
endpackage : uoec_pkg

/* File: design/uoec_flag.sv */
// ==========================================================
// sticky flag: a set in the same cycle as a clear wins
// ==========================================================
module uoec_flag #(
  parameter int W = 1
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic [W-1:0] set_i,
  input wire logic [W-1:0] clr_i,
  output logic [W-1:0] flag_o
);
  // set has priority so an event landing on a clear is never lost
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flag_o <= '0;
    end else if (ce_i) begin
      flag_o <= set_i | (flag_o & ~clr_i);
    end
  end
endmodule : uoec_flag

/* File: test/uoec_top_monitor.sv */
`include "uoec_regs.svh"
// ==========
// port checker of the receive endpoint block
module uoec_top_mon
  import uoec_pkg::*;
#(
  parameter logic [3:0] RX_EP_TOTAL = 4'h1,
  parameter logic [3:0] TX_EP_TOTAL = 4'h1,
  parameter logic [3:0] DMA_CH_TOTAL = 4'h1,
  parameter logic [3:0] RAM_AW_LESS_ONE = 4'h5
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [31:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic pkt_end_i,
  input wire logic hs_valid_o,
  input wire uoec_pkg::uoec_hs_t hs_code_o,
  input wire logic data_toggle_o,
  input wire logic dma_req_o,
  input wire logic ep_irq_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  // ack low keeps a held request from counting twice
  logic take;
  logic csr_wr;
  logic rd_done;
  assign take = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign csr_wr = take && wb_we_i && wb_sel_i[0]
    && wb_adr_i == `UOEC_CSR_ADDR;
  // ==========
  // assertions
  AST_ACK_NEXT: assert property (take |=> wb_ack_o)
    else $error("bus request not answered next cycle");
  AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held over one cycle");
  AST_CSR_UNUSED: assert property (wb_ack_o && !$past(wb_we_i) &&
    $past(wb_adr_i) == `UOEC_CSR_ADDR |-> wb_dat_o[10:9] == 2'h0)
    else $error("unused status bits not zero");
  AST_EP_INFO: assert property (wb_ack_o && !$past(wb_we_i) &&
    $past(wb_adr_i) == `UOEC_EP_TOTAL_ADDR
    |-> wb_dat_o[7:0] == {RX_EP_TOTAL, TX_EP_TOTAL})
    else $error("endpoint info wrong");
  AST_MEM_INFO: assert property (wb_ack_o && !$past(wb_we_i) &&
    $past(wb_adr_i) == `UOEC_MEM_INFO_ADDR
    |-> wb_dat_o[7:0] == {DMA_CH_TOTAL, RAM_AW_LESS_ONE})
    else $error("memory info wrong");
  AST_HS_CAUSE: assert property (hs_valid_o |-> $past(pkt_end_i))
    else $error("handshake without packet end");
  AST_IRQ_CAUSE: assert property (ep_irq_o |-> $past(pkt_end_i))
    else $error("interrupt without packet end");
  AST_DMA_CAUSE: assert property ($rose(dma_req_o)
    |-> $past(pkt_end_i))
    else $error("dma request without packet end");
  AST_TOG_ZERO: assert property (csr_wr && wb_dat_i[7]
    |=> !data_toggle_o)
    else $error("toggle not reset");
  AST_DMA_DROP: assert property (csr_wr && !wb_dat_i[0]
    |-> ##[1:2] !dma_req_o)
    else $error("dma request kept after ready cleared");
  // ==========
  // main scenarios seen
  COV_STALL: cover property (hs_valid_o && hs_code_o == `UOEC_HS_STALL);
  COV_DMA: cover property ($rose(dma_req_o));
  COV_IRQ: cover property (ep_irq_o);
endmodule : uoec_top_mon
bind uoec_top uoec_top_mon #(.RX_EP_TOTAL(RX_EP_TOTAL),
  .TX_EP_TOTAL(TX_EP_TOTAL), .DMA_CH_TOTAL(DMA_CH_TOTAL),
  .RAM_AW_LESS_ONE(RAM_AW_LESS_ONE)) mon_u (.clk_i(clk_i),
  .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
  .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .pkt_end_i(pkt_end_i), .hs_valid_o(hs_valid_o),
  .hs_code_o(hs_code_o), .data_toggle_o(data_toggle_o),
  .dma_req_o(dma_req_o), .ep_irq_o(ep_irq_o));

/* File: test/uoec_usb_host.sv */
// ==========
// host side: sends out packets byte by byte
module uoec_usb_host (
  input wire logic clk_i,
  output logic pkt_start_o,
  output logic pkt_byte_valid_o,
  output logic [7:0] pkt_byte_o,
  output logic pkt_end_o,
  output logic crc_err_o,
  output logic pid_err_o,
  output logic partial_o,
  output logic toggle_o
);
  timeunit 1ns;
  timeprecision 1ps;
  int seed = 32'he2d3;
  logic [7:0] sent_q[$]; // bytes of the last packet
  initial begin
    {pkt_start_o, pkt_byte_valid_o, pkt_end_o} = 3'h0;
    {toggle_o, partial_o, pid_err_o, crc_err_o} = 4'h0;
    pkt_byte_o = 8'h00;
  end
  // st is {toggle, partial, pid error, crc error}
  task send(input int len, input logic [3:0] st);
    logic [7:0] b;
    b = 8'h00;
    sent_q.delete();
    @(posedge clk_i);
    pkt_start_o <= 1'h1;
    for (int i = 0; i < len; i++) begin
      b = 8'($random(seed));
      sent_q.push_back(b);
      @(posedge clk_i);
      pkt_start_o <= 1'h0;
      pkt_byte_valid_o <= 1'h1;
      pkt_byte_o <= b;
    end
    @(posedge clk_i);
    pkt_start_o <= 1'h0;
    pkt_byte_valid_o <= 1'h0;
    // idle data line shows the inverse, never a stale byte
    pkt_byte_o <= ~b;
    pkt_end_o <= 1'h1;
    {toggle_o, partial_o, pid_err_o, crc_err_o} <= st;
    @(posedge clk_i);
    pkt_end_o <= 1'h0;
    {toggle_o, partial_o, pid_err_o, crc_err_o} <= ~st;
  endtask : send
endmodule : uoec_usb_host

/* File: test/uoec_top_bench.sv */
`include "uoec_regs.svh"
// ==========
// self-checking bench of the receive endpoint block
module uoec_top_bench
  import uoec_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 1'h0;
  logic rst_i = 1'h1;
  logic ce_i = 1'h1;
  logic wb_cyc_i = 1'h0, wb_stb_i = 1'h0, wb_we_i = 1'h0;
  logic [31:0] wb_adr_i = 32'h0000_0000, wb_dat_i = 32'h0000_0000;
  logic [3:0] wb_sel_i = 4'h0;
  logic high_speed_i = 1'h1, high_bw_i = 1'h0;
  logic pkt_start_i, pkt_byte_valid_i, pkt_end_i, pkt_crc_err_i;
  logic pkt_pid_err_i, pkt_partial_i, pkt_toggle_i;
  logic [7:0] pkt_byte_i;
  logic [31:0] wb_dat_o;
  logic wb_ack_o, hs_valid_o, data_toggle_o, dma_req_o, ep_irq_o;
  uoec_hs_t hs_code_o;
  int failures = 0, total_checks = 0, cycles = 0, irqs = 0, n = 0;
  logic [63:0] rd_q[$]; // {lane mask, expected} per read
  uoec_hs_t hs_q[$]; // expected handshakes
  localparam logic [31:0] CSR = `UOEC_CSR_ADDR;
  localparam logic [31:0] EP1 = 32'h0000_0024;
  localparam logic [31:0] M16 = 32'h0000_FFFF;
  localparam logic [31:0] ALL = 32'hFFFF_FFFF;
  initial forever #2 clk_i = ~clk_i;
  uoec_top #(.MAX_PAYLOAD(8)) dut_u (.clk_i(clk_i), .rst_i(rst_i),
    .ce_i(ce_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .high_speed_i(high_speed_i), .high_bw_i(high_bw_i),
    .pkt_start_i(pkt_start_i), .pkt_byte_valid_i(pkt_byte_valid_i),
    .pkt_byte_i(pkt_byte_i), .pkt_end_i(pkt_end_i),
    .pkt_crc_err_i(pkt_crc_err_i), .pkt_pid_err_i(pkt_pid_err_i),
    .pkt_partial_i(pkt_partial_i), .pkt_toggle_i(pkt_toggle_i),
    .hs_valid_o(hs_valid_o), .hs_code_o(hs_code_o),
    .data_toggle_o(data_toggle_o), .dma_req_o(dma_req_o),
    .ep_irq_o(ep_irq_o));
  uoec_usb_host host_u (.clk_i(clk_i), .pkt_start_o(pkt_start_i),
    .pkt_byte_valid_o(pkt_byte_valid_i), .pkt_byte_o(pkt_byte_i),
    .pkt_end_o(pkt_end_i), .crc_err_o(pkt_crc_err_i),
    .pid_err_o(pkt_pid_err_i), .partial_o(pkt_partial_i),
    .toggle_o(pkt_toggle_i));
  // ==========
  // checking and closing
  task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e) begin
      failures++;
      $display("CHECK FAILED %s exp %h seen %h", nm, e, s);
    end
  endtask : chk
  task wrap_up();
    if (failures == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : wrap_up
  // ==========
  // bus master: request held until ack is sampled high
  task bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge clk_i);
    wb_cyc_i <= 1'h1;
    wb_stb_i <= 1'h1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_sel_i <= w ? 4'h3 : 4'hF;
    wb_dat_i <= d;
    do @(posedge clk_i); while (wb_ack_o !== 1'h1);
    wb_cyc_i <= 1'h0;
    wb_stb_i <= 1'h0;
    wb_we_i <= 1'h0;
  endtask : bus
  task rd(input logic [31:0] a, input logic [31:0] m, input logic [31:0] e);
    rd_q.push_back({m, e});
    bus(1'h0, a, 32'h0000_0000);
  endtask : rd
  task wr(input logic [15:0] v);
    bus(1'h1, CSR, {16'h0000, v});
  endtask : wr
  // a bulk packet notes its handshake; iso expects none
  task pkt(input int len, input logic [2:0] st, input logic bulk,
    input uoec_hs_t hs);
    if (bulk) hs_q.push_back(hs);
    host_u.send(len, {data_toggle_o, st});
    repeat (4) @(posedge clk_i);
  endtask : pkt
  function automatic logic [31:0] word(input int i);
    word = {host_u.sent_q[i+3], host_u.sent_q[i+2],
      host_u.sent_q[i+1], host_u.sent_q[i]};
  endfunction : word
  // ==========
  // output watcher: takes the oldest note for each answer
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      wrap_up();
    end
    if (ep_irq_o === 1'h1) irqs++;
    if (wb_ack_o === 1'h1 && wb_we_i === 1'h0 && rd_q.size() > 0) begin
      chk("read", wb_dat_o & rd_q[0][63:32],
        rd_q[0][31:0] & rd_q[0][63:32]);
      void'(rd_q.pop_front());
    end
    if (hs_valid_o === 1'h1) begin
      if (hs_q.size() == 0) chk("handshake", 32'h1, 32'h0);
      else chk("handshake", 32'(hs_code_o), 32'(hs_q.pop_front()));
    end
  end
  // ==========
  // main sequence
  initial begin
    repeat (10) @(posedge clk_i);
    rst_i <= 1'h0;
    rd(CSR, M16, 32'h0000_0000);
    rd(`UOEC_EP_TOTAL_ADDR, 32'h0000_00FF, 32'h0000_0011);
    rd(`UOEC_MEM_INFO_ADDR, 32'h0000_00FF, 32'h0000_0015);
    rd(`UOEC_COUNT_ADDR, 32'h0000_1FFF, 32'h0000_0000);
    rd(32'h0000_0028, ALL, 32'h0000_0000);
    rd(32'h0000_0060, ALL, 32'h0000_0000);
    pkt(8, 3'h0, 1'h1, `UOEC_HS_NYET);
    rd(CSR, M16, 32'h0000_0003);
    rd(`UOEC_COUNT_ADDR, 32'h0000_1FFF, 32'h0000_0008);
    rd(EP1, ALL, word(0));
    rd(`UOEC_COUNT_ADDR, 32'h0000_1FFF, 32'h0000_0004);
    rd(EP1, ALL, word(4));
    wr(16'h0000);
    chk("toggle", 32'(data_toggle_o), 32'h1);
    wr(16'h0080);
    chk("toggle", 32'(data_toggle_o), 32'h0);
    wr(16'h1000);
    pkt(4, 3'h0, 1'h1, `UOEC_HS_ACK);
    pkt(4, 3'h0, 1'h1, `UOEC_HS_NAK);
    wr(16'h0020);
    pkt(4, 3'h0, 1'h1, `UOEC_HS_STALL);
    rd(CSR, M16, 32'h0000_0060);
    wr(16'h0000);
    rd(CSR, M16, 32'h0000_0000);
    high_bw_i <= 1'h1;
    wr(16'h4000);
    pkt(4, 3'h7, 1'h0, `UOEC_HS_ACK);
    rd(CSR, M16, 32'h0000_510B);
    pkt(4, 3'h0, 1'h0, `UOEC_HS_ACK);
    rd(CSR, M16, 32'h0000_510F);
    wr(16'h4015);
    rd(CSR, M16, 32'h0000_4004);
    wr(16'h4020);
    pkt(4, 3'h0, 1'h0, `UOEC_HS_ACK);
    rd(CSR, M16, 32'h0000_4023);
    wr(16'h0000);
    high_bw_i <= 1'h0;
    wr(16'h2080);
    n = irqs;
    pkt(5, 3'h0, 1'h1, `UOEC_HS_NYET);
    chk("dma", 32'(dma_req_o), 32'h1);
    chk("irq", irqs, n + 1);
    rd(EP1, ALL, word(0));
    rd(EP1, 32'h0000_00FF, word(4));
    repeat (2) @(posedge clk_i);
    chk("dma", 32'(dma_req_o), 32'h0);
    wr(16'h2800);
    n = irqs;
    pkt(8, 3'h0, 1'h1, `UOEC_HS_NYET);
    chk("dma", 32'(dma_req_o), 32'h1);
    chk("irq", irqs, n);
    rd(EP1, ALL, word(0));
    rd(EP1, ALL, word(4));
    repeat (2) @(posedge clk_i);
    chk("dma", 32'(dma_req_o), 32'h0);
    wr(16'h2800);
    n = irqs;
    pkt(3, 3'h0, 1'h1, `UOEC_HS_NYET);
    chk("dma", 32'(dma_req_o), 32'h0);
    chk("irq", irqs, n + 1);
    high_speed_i <= 1'h0;
    wr(16'h0000);
    pkt(2, 3'h0, 1'h1, `UOEC_HS_ACK);
    wr(16'h0000);
    wrap_up();
  end
endmodule : uoec_top_bench
